/* sfl_bank.sv */
// Top of the sink fade and level register bank with its fade ramp engine.
// Assumes reg_* strobes come from the serial host decoder on clk_i, one byte per write.
//
// Summary of operation
// - The upper nibble of the fade register sets the fade-out time, zero meaning no ramp.
// - Fade codes 1 to 10 step 0.3 s up to 3.0 s and codes 11 to 15 add 0.5 s to 5.5 s.
// - The time covers a full-scale swing, so a smaller swing finishes proportionally sooner.
// - The low nibble of the fade register sets the fade-in time, zero meaning no ramp.
// - Fade-in codes use the same duration table as fade-out codes.
// - The first sink level register holds a 7-bit code with bit 7 reserved and ignored.
// - The code maps nonlinearly to current, 0 being off and all ones being 30 mA full scale.
// - The first sink level register answers at address 0x1F.
// - An enabled sink with off time disabled stays on steadily at its programmed level.
`timescale 1ns/10ps
module sfl_bank
    import sfl_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = SFL_CYC_PER_MS
) (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       sink_enable_bit_i,
    input  wire logic [1:0] sink_off_time_field_i,
    output logic [7:0]      reg_rdata_o,
    output logic [6:0]      sink_code_o
);
    sfl_cfg_if cfg ();

    logic [7:0] fade;
    logic [7:0] next_fade;
    logic [6:0] level;
    logic [6:0] next_level;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic       en_q;
    logic [1:0] off_q;
    logic [6:0] ramp_code;

    always_comb begin
        next_fade  = fade;
        next_level = level;
        if (reg_wr_i && reg_addr_i == SFL_FADE_ADDR) begin
            next_fade = reg_wdata_i;
        end
        if (reg_wr_i && reg_addr_i == SFL_LEVEL1_ADDR) begin
            next_level = reg_wdata_i[SFL_LEVEL_W-1:0];
        end
        case (reg_addr_i)
            SFL_FADE_ADDR:   next_rdata = fade;
            SFL_LEVEL1_ADDR: next_rdata = {1'b0, level};
            default:         next_rdata = SFL_UNMAPPED;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fade  <= SFL_FADE_RST;
            level <= SFL_LEVEL_RST;
            rdata <= SFL_UNMAPPED;
            en_q  <= 1'b0;
            off_q <= SFL_OFF_DISABLED;
        end else begin
            fade  <= next_fade;
            level <= next_level;
            rdata <= next_rdata;
            en_q  <= sink_enable_bit_i;
            off_q <= sink_off_time_field_i;
        end
    end

    assign cfg.fade_out_time_code  = fade[SFL_FADE_OUT_LSB +: SFL_CODE_W];
    assign cfg.fade_in_time_code   = fade[SFL_FADE_IN_LSB +: SFL_CODE_W];
    assign cfg.led1_level_code     = level;
    assign cfg.sink_enable_bit     = en_q;
    assign cfg.sink_off_time_field = off_q;

    sfl_ramp #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_ramp (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .cfg     (cfg),
        .code_o  (ramp_code)
    );

    // code passed to the nonlinear converter
    assign reg_rdata_o = rdata;
    assign sink_code_o = ramp_code;

    fade_write_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == SFL_FADE_ADDR) |=> fade == $past(reg_wdata_i))
        else $error("fade register write lost");

    level_write_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == SFL_LEVEL1_ADDR) |=> level == $past(reg_wdata_i[6:0]))
        else $error("level register write at 0x1F lost");

    resv_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ($past(reg_addr_i) == SFL_LEVEL1_ADDR) |-> reg_rdata_o[SFL_RESV_BIT] == 1'b0)
        else $error("reserved level bit read back nonzero");

    nibble_split_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == SFL_FADE_ADDR) |=>
        cfg.fade_in_time_code == $past(reg_wdata_i[3:0])
        && cfg.fade_out_time_code == $past(reg_wdata_i[7:4]))
        else $error("fade nibbles misplaced");

    unmapped_write_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i != SFL_FADE_ADDR && reg_addr_i != SFL_LEVEL1_ADDR)
        |=> fade == $past(fade) && level == $past(level))
        else $error("unmapped write changed a register");

    idle_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (!reg_wr_i) |=> fade == $past(fade) && level == $past(level))
        else $error("register changed without a write");

    // Read data lags the address by one edge
    fade_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ($past(reg_addr_i) == SFL_FADE_ADDR) |-> reg_rdata_o == $past(fade))
        else $error("fade register read wrong");

    level_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ($past(reg_addr_i) == SFL_LEVEL1_ADDR) |-> reg_rdata_o == {1'b0, $past(level)})
        else $error("level register read wrong");

    unmapped_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        ($past(reg_addr_i) != SFL_FADE_ADDR && $past(reg_addr_i) != SFL_LEVEL1_ADDR)
        |-> reg_rdata_o == SFL_UNMAPPED)
        else $error("unmapped read not zero");

    level_readback_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == SFL_LEVEL1_ADDR) ##1
        (!reg_wr_i && reg_addr_i == SFL_LEVEL1_ADDR)
        |=> reg_rdata_o == {1'b0, $past(reg_wdata_i[6:0], 2)})
        else $error("level write not read back");

    // Guarded by reset history so a level held during reset cannot fire it
    enable_stage_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        $past(rst_b_i) |-> cfg.sink_enable_bit == $past(sink_enable_bit_i)
        && cfg.sink_off_time_field == $past(sink_off_time_field_i))
        else $error("enable or off time not staged once");

    disabled_zero_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (!cfg.sink_enable_bit && cfg.fade_out_time_code == SFL_FADE_NONE)
        |=> sink_code_o == 7'h00)
        else $error("disabled sink without fade-out not at zero");

    direct_level_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (cfg.sink_enable_bit && cfg.fade_in_time_code == SFL_FADE_NONE
         && cfg.fade_out_time_code == SFL_FADE_NONE)
        |=> sink_code_o == $past(cfg.led1_level_code))
        else $error("unfaded sink not at its level");

    no_overshoot_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (cfg.sink_enable_bit && sink_code_o <= cfg.led1_level_code)
        |=> sink_code_o <= $past(cfg.led1_level_code))
        else $error("fade-in passed its target");
endmodule

/* sfl_cfg_if.sv */
// Carrier of register contents from the bank to the ramp engine.
// Assumes both ends share clk_i.
`timescale 1ns/10ps
interface sfl_cfg_if;
    logic [3:0] fade_out_time_code;
    logic [3:0] fade_in_time_code;
    logic [6:0] led1_level_code;
    logic       sink_enable_bit;
    logic [1:0] sink_off_time_field;
    modport bank (output fade_out_time_code, fade_in_time_code, led1_level_code,
                  sink_enable_bit, sink_off_time_field);
    modport ramp (input fade_out_time_code, fade_in_time_code, led1_level_code,
                  sink_enable_bit, sink_off_time_field);
endinterface

/* sfl_host.sv */
// Host model: byte writes and reads as the serial decoder presents them.
// Assumes the bank samples on rising clk_i edges.
`timescale 1ns/10ps
module sfl_host (
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       clk_i,
    output logic            reg_wr_o,
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o
);
    initial begin
        reg_wr_o    = 1'b0;
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
    end
    // One-cycle strobe, launched off the sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_wr_o    = 1'b1;
        reg_addr_o  = a;
        reg_wdata_o = d;
        @(negedge clk_i);
        reg_wr_o    = 1'b0;
        reg_wdata_o = ~d;
    endtask
    // Read data follows the address by one edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        @(negedge clk_i);
        d = reg_rdata_i;
    endtask
endmodule

/* sfl_pkg.sv */
// Constants for the sink fade and level register bank.
// Assumes a single 200 MHz clock and an 8-bit register port from the serial host decoder.
package sfl_pkg;
    localparam logic [7:0]  SFL_FADE_ADDR    = 8'h1E;
    localparam logic [7:0]  SFL_LEVEL1_ADDR  = 8'h1F;
    localparam int unsigned SFL_FADE_OUT_LSB = 4;
    localparam int unsigned SFL_FADE_IN_LSB  = 0;
    localparam int unsigned SFL_CODE_W       = 4;
    localparam int unsigned SFL_LEVEL_W      = 7;
    localparam int unsigned SFL_RESV_BIT     = 7;
    localparam logic [7:0]  SFL_FADE_RST     = 8'h00;
    localparam logic [6:0]  SFL_LEVEL_RST    = 7'h00;
    localparam logic [7:0]  SFL_UNMAPPED     = 8'h00;
    localparam logic [1:0]  SFL_OFF_DISABLED = 2'h0;
    localparam logic [3:0]  SFL_FADE_NONE    = 4'h0;
    localparam logic [3:0]  SFL_FADE_KNEE    = 4'hA;
    localparam int unsigned SFL_FADE_BASE_MS = 300;
    localparam int unsigned SFL_FADE_KNEE_MS = 3000;
    localparam int unsigned SFL_FADE_ADD_MS  = 500;
    localparam int unsigned SFL_FULL_STEPS   = 127;
    localparam int unsigned SFL_CLK_HZ       = 200000000;
    localparam int unsigned SFL_CYC_PER_MS   = SFL_CLK_HZ / 1000;
endpackage

/* sfl_ramp.sv */
// Fade ramp engine for the first LED sink: walks the current code to its target.
// Assumes settings arrive already registered on clk_i.
`timescale 1ns/10ps
module sfl_ramp
    import sfl_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = SFL_CYC_PER_MS
) (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    sfl_cfg_if.ramp         cfg,
    output logic [6:0]      code_o
);
    logic [6:0]  cur;
    logic [6:0]  next_cur;
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic [6:0]  target;
    logic        rising;
    logic [3:0]  dir_code;
    logic [31:0] step_len;

    function automatic logic [31:0] sfl_fade_ms(input logic [3:0] c);
        logic [31:0] cw;
        cw = {28'h0000000, c};
        if (c <= SFL_FADE_KNEE) begin
            return cw * SFL_FADE_BASE_MS;
        end
        return SFL_FADE_KNEE_MS + (cw - 32'(SFL_FADE_KNEE)) * SFL_FADE_ADD_MS;
    endfunction

    always_comb begin
        target   = cfg.sink_enable_bit ? cfg.led1_level_code : SFL_LEVEL_RST;
        rising   = target > cur;
        dir_code = rising ? cfg.fade_in_time_code : cfg.fade_out_time_code;
        step_len = (sfl_fade_ms(dir_code) * CYC_PER_MS) / SFL_FULL_STEPS;
        if (step_len == 32'h00000000) begin
            step_len = 32'h00000001;
        end
        next_cur = cur;
        next_cnt = cnt;
        if (cur == target) begin
            next_cnt = 32'h00000000;
        end else if (dir_code == SFL_FADE_NONE) begin
            next_cur = target;
            next_cnt = 32'h00000000;
        end else if (cnt >= step_len - 32'h00000001) begin
            next_cnt = 32'h00000000;
            next_cur = rising ? cur + 7'h01 : cur - 7'h01;
        end else begin
            next_cnt = cnt + 32'h00000001;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cur <= 7'h00;
            cnt <= 32'h00000000;
        end else begin
            cur <= next_cur;
            cnt <= next_cnt;
        end
    end

    assign code_o = cur;

    step_jump_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (cur != target && dir_code == SFL_FADE_NONE) |=> cur == $past(target))
        else $error("disabled fade did not jump to target");

    step_size_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (cur != target && dir_code != SFL_FADE_NONE) |=>
        (cur == $past(cur) || cur == $past(cur) + 7'h01 || cur == $past(cur) - 7'h01))
        else $error("ramp moved more than one code");

    step_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (cur != target && dir_code != SFL_FADE_NONE && cnt < step_len - 32'h00000001)
        |=> cur == $past(cur))
        else $error("ramp stepped before its step time");

    fade_table_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (dir_code == 4'hF) |-> step_len == (32'd5500 * CYC_PER_MS) / 32'd127)
        else $error("top fade code has wrong duration");

    steady_on_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        (cfg.sink_enable_bit && cfg.sink_off_time_field == SFL_OFF_DISABLED
         && cur == cfg.led1_level_code && $stable(cfg.led1_level_code)
         && $stable(cfg.sink_enable_bit)) |=> cur == $past(cur))
        else $error("enabled steady sink left its level");
endmodule

/* tb_sfl_bank.sv */
// Self-checking bench for the sink fade and level register bank.
// Assumes CYC_PER_MS of 2, so a code 1 step is 4 cycles, code 11 55 and code 15 86.
`timescale 1ns/10ps
module tb_sfl_bank
    import sfl_pkg::*;
;
    logic       clk_i   = 1'b0;
    logic       rst_b_i = 1'b0;
    logic       en      = 1'b0;
    logic [1:0] off     = SFL_OFF_DISABLED;
    logic       reg_wr_i;
    logic [7:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic [7:0] reg_rdata_o;
    logic [7:0] rd;
    logic [6:0] sink_code_o;
    int         fails = 0;
    int         samples_checked = 0;
    always #2.5 clk_i = ~clk_i;
    sfl_host host (.clk_i(clk_i), .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i),
                   .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
    sfl_bank #(.CYC_PER_MS(2)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .sink_enable_bit_i(en),
        .sink_off_time_field_i(off), .reg_rdata_o(reg_rdata_o),
        .sink_code_o(sink_code_o));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic t_regs;
        host.rd(SFL_FADE_ADDR, rd);
        check("fade reset", SFL_FADE_RST, rd);
        host.wr(8'h1F, 8'hC5);
        host.rd(8'h1F, rd);
        check("level bit 7 dropped", 8'h45, rd);
        host.wr(8'h20, 8'hFF);
        host.rd(8'h20, rd);
        check("unmapped read", SFL_UNMAPPED, rd);
        host.rd(8'h1F, rd);
        check("level kept", 8'h45, rd);
        host.wr(SFL_FADE_ADDR, 8'hA5);
        host.rd(SFL_FADE_ADDR, rd);
        check("fade nibbles", 8'hA5, rd);
        $display("test regs done");
    endtask
    task automatic t_step;
        host.wr(SFL_FADE_ADDR, 8'h00);
        host.wr(8'h1F, 8'h7F);
        en = 1'b1;
        cyc(3);
        check("jump to full scale", 8'h7F, {1'b0, sink_code_o});
        host.rd(SFL_LEVEL1_ADDR, rd);
        check("full scale code", 8'h7F, rd);
        cyc(40);
        check("steady while on", 8'h7F, {1'b0, sink_code_o});
        en = 1'b0;
        cyc(3);
        check("jump to zero", 8'h00, {1'b0, sink_code_o});
        $display("test step done");
    endtask
    task automatic t_fade;
        host.wr(SFL_FADE_ADDR, 8'hF1);
        host.wr(8'h1F, 8'h10);
        en = 1'b1;
        cyc(10);
        check("fade in midway", 8'h01, {7'h0, sink_code_o > 0 && sink_code_o < 7'h10});
        cyc(60);
        check("short swing done", 8'h10, {1'b0, sink_code_o});
        en = 1'b0;
        cyc(400);
        check("fade out midway", 8'h01, {7'h0, sink_code_o > 9 && sink_code_o < 14});
        cyc(850);
        check("fade out not done", 8'h01, {7'h0, sink_code_o != 0});
        cyc(200);
        check("fade out done", 8'h00, {1'b0, sink_code_o});
        $display("test fade done");
    endtask
    // First code past the knee: 3500 ms full swing
    task automatic t_knee;
        host.wr(SFL_FADE_ADDR, 8'h0B);
        host.wr(SFL_LEVEL1_ADDR, 8'h01);
        en = 1'b1;
        cyc(55);
        check("code 11 step not early", 8'h00, {1'b0, sink_code_o});
        cyc(1);
        check("code 11 step on time", 8'h01, {1'b0, sink_code_o});
        en = 1'b0;
        cyc(3);
        check("zero fade-out jumps", 8'h00, {1'b0, sink_code_o});
        $display("test knee done");
    endtask
    initial begin
        #100us;
        fails++;
        summarize();
    end
    initial begin
        cyc(8);
        rst_b_i = 1'b1;
        t_regs();
        t_step();
        t_fade();
        t_knee();
        summarize();
    end
endmodule
